/* verilog/adc_conversion_sequencer.sv */
// APB-controlled sequencer for a 12-bit successive-approximation converter
//
// How it works
// - Divider codes 0 to 6 give system clock over 1 to 64.
// - Converter is powered only while the power-off bit is clear.
// - With power-off set, the converter is disabled whatever the inputs; bandgap enable still follows its bit.
// - Channel choice uses bits split across both control registers.
// - Each pin enable bit makes its pin an analog input or not.
// - Enabled pins lose pull-high and direction control of the port.
// - Reference is supply or reference pin; pin choice overrides pin function.
// - Interrupt only when global and conversion enables are both set.
// - A low-high-low pulse on the start bit begins a conversion.
// - Busy flag is readable and falls when the conversion ends.
// - With busy low, the result sits in the low and high bytes.
// - Completion raises the interrupt request when enabled.
// - A conversion takes sixteen converter clock periods.
// - Conversion runs in hardware while the processor does other work.
// - After reset all shared pins are analog inputs.
// - Result is 12-bit unsigned, full scale all ones.
// - One step is reference over 4096.
// - Analog offset shifts transitions half a step; top code 1.5 below.
// - Writing 03h to second control selects over 8, bandgap off.
// - Writing zero to first control powers on and picks channel zero.
// - Writing 0Fh to pin enables makes channels 0 to 3 inputs.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
module adc_conversion_sequencer (
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       ce_i,
   input  wire adc_seq_pkg::apb_req_type   apb_req_i,
   output adc_seq_pkg::apb_rsp_type        apb_rsp_o,
   input  wire logic                       cmp_i,
   output logic [11:0]                     dac_code_o,
   output logic                            sample_o,
   output logic [3:0]                      channel_o,
   output logic                            power_en_o,
   output logic                            bandgap_en_o,
   output adc_seq_pkg::pin_ctrl_type       pins_o,
   output logic                            irq_o
);
   import adc_seq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [2:0]     chan_low_q;
   logic           chan_high_q;
   logic           power_off_q;
   logic           start_q;
   logic [2:0]     div_sel_q;
   logic           bandgap_on_q;
   logic           ref_sel_q;
   logic [7:0]     pin_en_q;
   logic           global_en_q;
   logic           conv_en_q;
   logic           flag_q;
   logic           irq_q;
   pin_ctrl_type   pins_q;
   conv_state_type state_q;
   conv_state_type state_d;
   logic [3:0]     period_q;
   logic [11:0]    trial_q;
   logic [11:0]    result_q;
   logic [31:0]    prdata_q;
   logic           cmp_meta_q;
   logic           cmp_q;
   logic           busy;
   logic           tick;
   logic           launch;
   logic           done;
   logic           setup;
   logic           wr;
   logic [7:0]     rd_byte;
   logic [7:0]     wdat;

   // Decodes whether a byte address holds a register
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `OFS_CTRL_FIRST) || (a == `OFS_CTRL_SECOND) ||
               (a == `OFS_PIN_ENABLE) || (a == `OFS_RESULT_LOW) ||
               (a == `OFS_RESULT_HIGH) || (a == `OFS_IRQ_CTRL);
   endfunction

   // Trial bit for a conversion period, zero outside the trial periods
   function automatic logic [11:0] trial_bit(input logic [3:0] p);
      if (p >= `FIRST_TRIAL && p <= `LAST_TRIAL) begin
         trial_bit = 12'h001 << (`LAST_TRIAL - p);
      end else begin
         trial_bit = 12'h000;
      end
   endfunction

   // Write request of the access phase for one register
   function automatic logic wr_to(input logic w, input logic [7:0] a, input logic [7:0] o);
      wr_to = w && (a == o);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states while ce_i is high, error on unmapped addresses
   assign setup = apb_req_i.psel && !apb_req_i.penable;
   assign wr    = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && ce_i &&
                  mapped(apb_req_i.paddr);
   assign wdat  = apb_req_i.pwdata[7:0];

   assign apb_rsp_o.prdata  = prdata_q;
   assign apb_rsp_o.pready  = ce_i;
   assign apb_rsp_o.pslverr = apb_req_i.psel && apb_req_i.penable &&
                              !mapped(apb_req_i.paddr);

   // Read data selection; reserved bits read as zero
   always_comb begin
      rd_byte = 8'h00;
      unique case (apb_req_i.paddr)
         `OFS_CTRL_FIRST: begin
            rd_byte[`CF_CHAN_MSB:`CF_CHAN_LSB] = chan_low_q;
            rd_byte[`CF_POWER_OFF]             = power_off_q;
            rd_byte[`CF_BUSY]                  = busy;
            rd_byte[`CF_START]                 = start_q;
         end
         `OFS_CTRL_SECOND: begin
            rd_byte[`CS_DIV_MSB:`CS_DIV_LSB] = div_sel_q;
            rd_byte[`CS_BANDGAP_ON]          = bandgap_on_q;
            rd_byte[`CS_CHAN_HIGH]           = chan_high_q;
            rd_byte[`CS_REF_SEL]             = ref_sel_q;
         end
         `OFS_PIN_ENABLE:  rd_byte = pin_en_q;
         `OFS_RESULT_LOW:  rd_byte = result_q[7:0];
         `OFS_RESULT_HIGH: rd_byte = {4'h0, result_q[11:8]};
         `OFS_IRQ_CTRL: begin
            rd_byte[`IR_GLOBAL_EN] = global_en_q;
            rd_byte[`IR_CONV_EN]   = conv_en_q;
            rd_byte[`IR_FLAG]      = flag_q;
         end
         default:          rd_byte = 8'h00;
      endcase
   end

   // Read data captured in the setup cycle, stable through the access phase
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_q <= 32'h0000_0000;
      end else if (ce_i && setup) begin
         prdata_q <= {24'h00_0000, rd_byte};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // First control register: channel low bits, power off, start
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chan_low_q  <= `RST_CHAN_LOW;
         power_off_q <= `RST_POWER_OFF;
         start_q     <= 1'b0;
      end else if (ce_i && wr_to(wr, apb_req_i.paddr, `OFS_CTRL_FIRST)) begin
         chan_low_q  <= wdat[`CF_CHAN_MSB:`CF_CHAN_LSB];
         power_off_q <= wdat[`CF_POWER_OFF];
         start_q     <= wdat[`CF_START];
      end
   end

   // Second control register: divider, bandgap, channel high bit, reference
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {ref_sel_q, chan_high_q, bandgap_on_q, div_sel_q} <= `RST_CTRL_SECOND;
      end else if (ce_i && wr_to(wr, apb_req_i.paddr, `OFS_CTRL_SECOND)) begin
         div_sel_q    <= wdat[`CS_DIV_MSB:`CS_DIV_LSB];
         bandgap_on_q <= wdat[`CS_BANDGAP_ON];
         chan_high_q  <= wdat[`CS_CHAN_HIGH];
         ref_sel_q    <= wdat[`CS_REF_SEL];
      end
   end

   // Pin enable register, all pins analog after reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_en_q <= `RST_PIN_ENABLE;
      end else if (ce_i && wr_to(wr, apb_req_i.paddr, `OFS_PIN_ENABLE)) begin
         pin_en_q <= wdat;
      end
   end

   // Interrupt enables and flag; completion wins over a clearing write
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         global_en_q <= 1'b0;
         conv_en_q   <= 1'b0;
         flag_q      <= 1'b0;
      end else if (ce_i) begin
         if (wr_to(wr, apb_req_i.paddr, `OFS_IRQ_CTRL)) begin
            global_en_q <= wdat[`IR_GLOBAL_EN];
            conv_en_q   <= wdat[`IR_CONV_EN];
         end
         if (done) begin
            flag_q <= 1'b1;
         end else if (wr_to(wr, apb_req_i.paddr, `OFS_IRQ_CTRL)) begin
            flag_q <= wdat[`IR_FLAG];
         end
      end
   end

   // Interrupt request gated by both enables
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_q <= 1'b0;
      end else if (ce_i) begin
         irq_q <= flag_q && global_en_q && conv_en_q;
      end
   end
   assign irq_o = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Comparator synchroniser
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmp_meta_q <= 1'b0;
         cmp_q      <= 1'b0;
      end else if (ce_i) begin
         cmp_meta_q <= cmp_i;
         cmp_q      <= cmp_meta_q;
      end
   end

   // Converter clock from the divided system clock
   adc_clock_divider u_div (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .run_i     (busy),
      .div_sel_i (div_sel_q),
      .tick_o    (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: start high holds it reset, falling start launches
   assign busy   = (state_q == ST_CONVERT);
   assign launch = (state_q == ST_ARMED) && !start_q && !power_off_q;
   assign done   = busy && tick && (period_q == `LAST_PERIOD) &&
                   !start_q && !power_off_q;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (start_q) state_d = ST_ARMED;
         end
         ST_ARMED: begin
            if (!start_q) state_d = power_off_q ? ST_IDLE : ST_CONVERT;
         end
         ST_CONVERT: begin
            if (start_q) state_d = ST_ARMED;
            else if (power_off_q || done) state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   // Period counter over the sixteen converter clock periods
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         period_q <= 4'h0;
      end else if (ce_i) begin
         if (launch) begin
            period_q <= 4'h0;
         end else if (busy && tick) begin
            period_q <= period_q + 4'h1;
         end
      end
   end

   // Successive approximation; the analog side adds the half-step offset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trial_q <= 12'h000;
      end else if (ce_i) begin
         if (launch) begin
            trial_q <= 12'h000;
         end else if (busy && tick) begin
            if (period_q == `SAMPLE_END) begin
               trial_q <= 12'h800;
            end else if (trial_bit(period_q) != 12'h000) begin
               trial_q <= (cmp_q ? trial_q : (trial_q & ~trial_bit(period_q))) |
                          trial_bit(period_q + 4'h1);
            end
         end
      end
   end

   // Result register loaded as busy falls
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_q <= 12'h000;
      end else if (ce_i && done) begin
         result_q <= trial_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin and analog controls
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pins_q <= '{`RST_PIN_ENABLE, `RST_PIN_ENABLE, 1'b0};
      end else if (ce_i) begin
         pins_q.pull_high_disable <= pin_en_q;
         pins_q.dir_override      <= pin_en_q;
         pins_q.vref_pin_sel      <= ref_sel_q;
      end
   end
   assign pins_o       = pins_q;
   assign dac_code_o   = trial_q;
   assign sample_o     = busy && (period_q < `FIRST_TRIAL);
   assign channel_o    = {chan_high_q, chan_low_q};
   assign power_en_o   = !power_off_q;
   assign bandgap_en_o = bandgap_on_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [4:0] tick_cnt_h;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt_h <= 5'h00;
      end else if (ce_i) begin
         if (launch) tick_cnt_h <= 5'h00;
         else if (busy && tick) tick_cnt_h <= tick_cnt_h + 5'h01;
      end
   end

   busy_launch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && launch) |=> busy && (period_q == 4'h0))
      else $error("busy did not rise at launch");

   conv_length_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && done) |=> !busy && (tick_cnt_h == 5'h10))
      else $error("conversion did not span sixteen periods");

   power_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && power_off_q) |-> !power_en_o ##1 !busy)
      else $error("converter active while powered off");

   irq_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(irq_o) |-> $past(global_en_q) && $past(conv_en_q) && $past(flag_q))
      else $error("interrupt without both enables");

   done_result_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && done) |=> flag_q && (result_q == $past(trial_q)))
      else $error("result or flag missing after completion");

   start_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && start_q) |=> !busy && (state_q == ST_ARMED))
      else $error("start high did not hold sequencer reset");

   pin_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i |=> (pins_o.dir_override == $past(pin_en_q)) &&
               (pins_o.vref_pin_sel == $past(ref_sel_q)))
      else $error("pin controls do not follow registers");

   sar_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && busy && tick && period_q == 4'h1 && !start_q && !power_off_q)
      |=> dac_code_o == 12'h800)
      else $error("first trial code not mid scale");

endmodule

/* verilog/adc_seq_consts.svh */
// Offsets, field positions, reset values and counts of the converter sequencer
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// Register byte addresses
`define OFS_CTRL_FIRST   8'h00
`define OFS_CTRL_SECOND  8'h04
`define OFS_PIN_ENABLE   8'h08
`define OFS_RESULT_LOW   8'h0C
`define OFS_RESULT_HIGH  8'h10
`define OFS_IRQ_CTRL     8'h14

// First control register fields
`define CF_CHAN_LSB      0
`define CF_CHAN_MSB      2
`define CF_POWER_OFF     5
`define CF_BUSY          6
`define CF_START         7

// Second control register fields
`define CS_DIV_LSB       0
`define CS_DIV_MSB       2
`define CS_BANDGAP_ON    3
`define CS_CHAN_HIGH     4
`define CS_REF_SEL       5

// Interrupt control register fields
`define IR_GLOBAL_EN     0
`define IR_CONV_EN       1
`define IR_FLAG          2

// Reset values
`define RST_POWER_OFF    1'b1
`define RST_CHAN_LOW     3'h0
`define RST_CTRL_SECOND  6'h00
`define RST_PIN_ENABLE   8'hFF

// Conversion timing in converter clock periods, and divider codes
`define CONV_PERIODS     16
`define LAST_PERIOD      4'hF
`define SAMPLE_END       4'h1
`define FIRST_TRIAL      4'h2
`define LAST_TRIAL       4'hD
`define DIV_CODE_UNDEF   3'h7
`define DIV_CODE_MAX     3'h6

`endif

/* verilog/adc_seq_pkg.sv */
// Types shared by the converter sequencer files
package adc_seq_pkg;

   // APB request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   // APB answer to the master
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_type;

   // Controls toward the shared analog pins
   typedef struct packed {
      logic [7:0] pull_high_disable;
      logic [7:0] dir_override;
      logic       vref_pin_sel;
   } pin_ctrl_type;

   // Conversion sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_CONVERT
   } conv_state_type;

endpackage

/* verilog/adc_clock_divider.sv */
// Converter clock enable generator dividing the system clock
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
module adc_clock_divider (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   input  wire logic       run_i,
   input  wire logic [2:0] div_sel_i,
   output logic            tick_o
);

   logic [5:0] cnt_q;

   // Last count value for a divider code; the undefined code acts as the largest
   function automatic logic [5:0] last_count(input logic [2:0] sel);
      logic [6:0] span;
      span = 7'h01 << ((sel == `DIV_CODE_UNDEF) ? `DIV_CODE_MAX : sel);
      last_count = 6'(span - 7'h01);
   endfunction

   // One tick per divided period while running
   assign tick_o = run_i && ce_i && (cnt_q == last_count(div_sel_i));

   ////////////////////////////////////////////////////////////////////////////
   // Period counter, restarted whenever the converter is not running
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 6'h00;
      end else if (ce_i) begin
         if (!run_i || tick_o) begin
            cnt_q <= 6'h00;
         end else begin
            cnt_q <= cnt_q + 6'h01;
         end
      end
   end

endmodule

/* tb/adc_conversion_sequencer_bench.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
   import adc_seq_pkg::*;

   logic         clk_i        = 1'b0;
   logic         rst_n_i      = 1'b0;
   logic         cmp_i        = 1'b0;
   logic         ce           = 1'b1;
   apb_req_type  req          = '0;
   apb_rsp_type  rsp;
   logic [11:0]  dac_code;
   logic         sample;
   logic [3:0]   channel;
   logic         power_en;
   logic         bandgap_en;
   pin_ctrl_type pins;
   logic         irq;
   logic [11:0]  target       = 12'h000;
   logic [31:0]  rd           = 32'h0;
   logic         serr         = 1'b0;
   int           err_count    = 0;
   int           total_checks = 0;
   int           cyc          = 0;

   adc_conversion_sequencer i_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .apb_req_i(req), .apb_rsp_o(rsp),
      .cmp_i(cmp_i), .dac_code_o(dac_code), .sample_o(sample), .channel_o(channel),
      .power_en_o(power_en), .bandgap_en_o(bandgap_en), .pins_o(pins), .irq_o(irq)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, comparator model and cycle counter with hang limit
   always #12.5 clk_i = ~clk_i;

   always @(posedge clk_i) begin
      cmp_i <= (target >= dac_code);
   end

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counts, verdict and end of run
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Compare one value and report a difference
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // One APB transfer; read data and error taken at the completing edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      @(posedge clk_i);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
      @(posedge clk_i);
      req.penable <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      serr = rsp.pslverr;
      req <= '0;
   endtask

   // Read a register and compare it
   task automatic rchk(input logic [7:0] addr, input logic [31:0] exp, input string what);
      apb(1'b0, addr, 32'h0);
      check(what, rd, exp);
   endtask

   // Wait until the sampling phase is seen, bounded
   task automatic wait_sample();
      int w;
      w = 0;
      while (sample !== 1'b1 && w < 50) begin
         @(posedge clk_i);
         #1;
         w++;
      end
   endtask

   // Full conversion with given divider code, channel and interrupt enables
   task automatic conv(input logic [2:0] dv, input logic [3:0] ch, input logic [1:0] en);
      int nper;
      int t0;
      int hits;
      nper = 1 << dv;
      hits = 0;
      apb(1'b1, 8'h04, {27'h0, ch[3], 1'b0, dv});
      apb(1'b1, 8'h14, {30'h0, en});
      apb(1'b1, 8'h00, {29'h0, ch[2:0]});
      apb(1'b1, 8'h00, {24'h0, 5'h10, ch[2:0]});
      apb(1'b1, 8'h00, {29'h0, ch[2:0]});
      check("channel", 32'(channel), 32'(ch));
      check("power", 32'(power_en), 32'h1);
      wait_sample();
      t0 = cyc;
      while (sample === 1'b1 && cyc - t0 < 200) begin
         @(posedge clk_i);
         #1;
      end
      check("sample width", 32'(cyc - t0), 32'(2 * nper));
      rchk(8'h00, {24'h0, 5'h08, ch[2:0]}, "busy high");
      if (en == 2'b11) begin
         while (irq !== 1'b1 && cyc - t0 < 1100) begin
            @(posedge clk_i);
            #1;
         end
         check("conversion time", 32'(cyc - t0), 32'(16 * nper + 1));
      end else begin
         repeat (16 * nper + 3) begin
            @(posedge clk_i);
            #1;
            hits = hits + int'(irq);
         end
         check("irq masked", 32'(hits), 32'h0);
      end
      rchk(8'h00, {29'h0, ch[2:0]}, "busy low");
      if (dv >= 3'h3) begin
         rchk(8'h0C, {24'h0, target[7:0]}, "result low");
         rchk(8'h10, {28'h0, target[11:8]}, "result high");
      end
      rchk(8'h14, {29'h1, en}, "flag set");
      apb(1'b1, 8'h14, 32'h0);
      repeat (2) @(posedge clk_i);
      #1;
      check("irq cleared", 32'(irq), 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int seed;
      seed = $urandom(75789);
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1;
      check("power after reset", 32'(power_en), 32'h0);
      check("pull after reset", 32'(pins.pull_high_disable), 32'hFF);
      check("dir after reset", 32'(pins.dir_override), 32'hFF);
      check("irq after reset", 32'(irq), 32'h0);
      rchk(8'h00, 32'h20, "first ctrl reset");
      rchk(8'h04, 32'h00, "second ctrl reset");
      rchk(8'h08, 32'hFF, "pin enable reset");
      apb(1'b0, 8'h30, 32'h0);
      check("unmapped error", 32'(serr), 32'h1);
      check("unmapped data", rd, 32'h0);
      apb(1'b1, 8'h04, 32'h0B);
      #1;
      check("bandgap on", 32'(bandgap_en), 32'h1);
      apb(1'b1, 8'h04, 32'h03);
      #1;
      check("bandgap off", 32'(bandgap_en), 32'h0);
      rchk(8'h04, 32'h03, "divider by eight");
      apb(1'b1, 8'h08, 32'h0F);
      apb(1'b1, 8'h00, 32'h00);
      apb(1'b1, 8'h04, 32'h20);
      repeat (2) @(posedge clk_i);
      #1;
      check("pull four pins", 32'(pins.pull_high_disable), 32'h0F);
      check("dir four pins", 32'(pins.dir_override), 32'h0F);
      check("power on", 32'(power_en), 32'h1);
      check("channel zero", 32'(channel), 32'h0);
      check("reference pin", 32'(pins.vref_pin_sel), 32'h1);
      for (int d = 0; d < 7; d++) begin
         target = 12'($urandom);
         conv(3'(d), 4'($urandom), 2'b11);
      end
      target = 12'hFFF;
      conv(3'h3, 4'hF, 2'b11);
      target = 12'h000;
      conv(3'h4, 4'h8, 2'b01);
      target = 12'($urandom);
      conv(3'h3, 4'h5, 2'b10);
      conv(3'h5, 4'h9, 2'b00);
      apb(1'b1, 8'h04, 32'h03);
      apb(1'b1, 8'h00, 32'h80);
      apb(1'b1, 8'h00, 32'h00);
      wait_sample();
      apb(1'b1, 8'h00, 32'hA0);
      rchk(8'h00, 32'hA0, "aborted busy");
      apb(1'b1, 8'h00, 32'h20);
      check("powered off", 32'(power_en), 32'h0);
      seed = 0;
      repeat (16 * 8 + 4) begin
         @(posedge clk_i);
         #1;
         seed = seed + int'(sample) + int'(irq);
      end
      check("no launch when off", 32'(seed), 32'h0);
      rchk(8'h14, 32'h0, "no flag after abort");
      // Clock enable low freezes a running conversion and holds pready low
      apb(1'b1, 8'h00, 32'h80);
      apb(1'b1, 8'h00, 32'h00);
      wait_sample();
      @(posedge clk_i);
      ce <= 1'b0;
      repeat (20) @(posedge clk_i);
      #1;
      check("frozen sample", 32'(sample), 32'h1);
      check("frozen pready", 32'(rsp.pready), 32'h0);
      @(posedge clk_i);
      ce <= 1'b1;
      repeat (16 * 8 + 4) @(posedge clk_i);
      rchk(8'h00, 32'h00, "resumed busy low");
      rchk(8'h14, 32'h04, "flag after resume");
      finish_test();
   end
endmodule
